// [core/acpm_pkg.sv]
// acpm_pkg: constants, field layouts and types of the converter clock and power control
// assumes one 100 MHz ref_clk domain and a register port fed by the serial port decoder
package acpm_pkg;
    localparam logic [7:0] ADDR_PWR  = 8'h08;
    localparam logic [7:0] ADDR_DCS  = 8'h09;
    localparam logic [7:0] ADDR_STAT = 8'h0a;
    localparam logic [7:0] ADDR_DIV  = 8'h0b;
    localparam logic [7:0] ADDR_VREF = 8'h18;

    localparam logic [1:0] PM_NORM = 2'h0;
    localparam logic [1:0] PM_DOWN = 2'h1;
    localparam logic [1:0] PM_STBY = 2'h2;

    localparam int DIV_MAX  = 8;
    localparam int DIV_W    = 3;
    localparam int VREF_W   = 5;
    localparam int PER_W    = 16;

    localparam logic [DIV_W-1:0] DIV_FIELD_ONE = 3'h0;
    localparam logic [7:0]       SPAN_BASE     = 8'h8c;
    localparam logic [7:0]       SPAN_STEP     = 8'h02;

    localparam real CLK_PERIOD_NS   = 10.0;
    localparam real RELOCK_MIN_US   = 1.5;
    localparam real RELOCK_MAX_US   = 5.0;
    localparam real DCS_MIN_RATE_MHZ = 40.0;
    localparam int  RELOCK_MIN_CYC  = int'($ceil(RELOCK_MIN_US * 1000.0 / CLK_PERIOD_NS));
    localparam int  RELOCK_MAX_CYC  = int'($floor(RELOCK_MAX_US * 1000.0 / CLK_PERIOD_NS));
    localparam int  DCS_MAX_PER_CYC =
        int'($floor(1000.0 / DCS_MIN_RATE_MHZ / CLK_PERIOD_NS));
    localparam int  RELOCK_W        = 10;

    typedef struct packed {
        logic ref_en;
        logic refbuf_en;
        logic bias_en;
        logic clk_en;
        logic out_en;
    } acpm_pwr_t;

    typedef enum logic [2:0] {
        LS_OFF  = 3'b001,
        LS_WAIT = 3'b010,
        LS_LOCK = 3'b100
    } acpm_lock_t;
endpackage

// [core/acpm_div.sv]
// acpm_div: integer input clock divider with period measurement
// assumes clk_rise and clk_level are already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
module acpm_div (
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    input  wire logic                          clk_rise,
    input  wire logic                          clk_level,
    input  wire logic [acpm_pkg::DIV_W-1:0]    ratio_m1,
    output logic                               div_rise_q,
    output logic                               div_level_q,
    output logic [acpm_pkg::PER_W-1:0]         period_q,
    output logic                               period_chg_q
);
    logic [acpm_pkg::DIV_W-1:0] cnt_q,  cnt_d;
    logic [acpm_pkg::PER_W-1:0] tim_q,  tim_d;
    logic [acpm_pkg::PER_W-1:0] period_d;
    logic                       div_rise_d, div_level_d, period_chg_d;

    always_comb begin
        cnt_d        = cnt_q;
        div_rise_d   = 1'b0;
        // one output edge per ratio input edges
        if (clk_rise) begin
            if (cnt_q >= ratio_m1) begin
                cnt_d      = '0;
                div_rise_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
        // raw divided level keeps the input's own high time
        div_level_d  = div_rise_d | (div_level_q & clk_level);
        tim_d        = div_rise_d ? acpm_pkg::PER_W'(1) :
                       (&tim_q ? tim_q : tim_q + 1'b1);
        period_d     = div_rise_d ? tim_q : period_q;
        period_chg_d = div_rise_d & (tim_q != period_q);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt_q        <= '0;
            tim_q        <= '0;
            period_q     <= '0;
            div_rise_q   <= 1'b0;
            div_level_q  <= 1'b0;
            period_chg_q <= 1'b0;
        end else begin
            cnt_q        <= cnt_d;
            tim_q        <= tim_d;
            period_q     <= period_d;
            div_rise_q   <= div_rise_d;
            div_level_q  <= div_level_d;
            period_chg_q <= period_chg_d;
        end
    end
endmodule
`default_nettype wire

// [core/acpm_top.sv]
// acpm_top: sample clock divider, duty cycle stabilizer, power modes, reference span
// assumes a register port on ref_clk from the serial decoder and a raw clock pin input
`timescale 1ns/1ps
`default_nettype none
module acpm_top #(
    parameter int                            DATA_W  = 12,
    parameter logic [acpm_pkg::DIV_W-1:0]    DIV_RST = 3'h0
) (
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    input  wire logic                        sample_clk_pin,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic [7:0]                       reg_rdata_q,
    input  wire logic [DATA_W-1:0]           conv_data,
    output logic [DATA_W-1:0]                data_out_q,
    output logic                             data_oe_q,
    output logic                             iclk_q,
    output logic                             sample_strobe_q,
    output acpm_pkg::acpm_pwr_t              pwr_q,
    output logic [7:0]                       span_q,
    output logic                             dcs_locked_q
);
    if (DATA_W < 1 || DATA_W > 16) begin : g_chk
        $error("acpm_top: DATA_W out of range");
    end

    // raw pin synchroniser and edge detect
    logic sync1_q, sync2_q, sync3_q;
    logic clk_rise;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= sample_clk_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign clk_rise = sync2_q & ~sync3_q;

    // registers
    logic [1:0]                    pm_q,    pm_d;
    logic [acpm_pkg::DIV_W-1:0]    ratio_q, ratio_d;
    logic                          dcs_en_q, dcs_en_d;
    logic [acpm_pkg::VREF_W-1:0]   vref_q,  vref_d;
    logic [7:0]                    rdata_d;
    acpm_pkg::acpm_lock_t          st_q, st_d;

    always_comb begin
        pm_d     = pm_q;
        ratio_d  = ratio_q;
        dcs_en_d = dcs_en_q;
        vref_d   = vref_q;
        if (reg_wr) begin
            unique case (reg_addr)
                acpm_pkg::ADDR_PWR:  pm_d     = reg_wdata[1:0];
                acpm_pkg::ADDR_DCS:  dcs_en_d = reg_wdata[0];
                acpm_pkg::ADDR_DIV:  ratio_d  = reg_wdata[acpm_pkg::DIV_W-1:0];
                acpm_pkg::ADDR_VREF: vref_d   = reg_wdata[acpm_pkg::VREF_W-1:0];
                default: ;
            endcase
        end
        rdata_d = reg_rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                acpm_pkg::ADDR_PWR:  rdata_d = {6'h00, pm_q};
                acpm_pkg::ADDR_DCS:  rdata_d = {7'h00, dcs_en_q};
                acpm_pkg::ADDR_STAT: rdata_d = {5'h00, st_q};
                acpm_pkg::ADDR_DIV:  rdata_d = {5'h00, ratio_q};
                acpm_pkg::ADDR_VREF: rdata_d = {3'h0, vref_q};
                default:             rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pm_q        <= acpm_pkg::PM_NORM;
            ratio_q     <= DIV_RST;
            dcs_en_q    <= (DIV_RST != acpm_pkg::DIV_FIELD_ONE);
            vref_q      <= '0;
            reg_rdata_q <= 8'h00;
        end else begin
            pm_q        <= pm_d;
            ratio_q     <= ratio_d;
            dcs_en_q    <= dcs_en_d;
            vref_q      <= vref_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // divider
    logic                          div_rise, div_level, period_chg;
    logic [acpm_pkg::PER_W-1:0]    period;
    acpm_div u_div (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .clk_rise     (clk_rise),
        .clk_level    (sync2_q),
        .ratio_m1     (ratio_q),
        .div_rise_q   (div_rise),
        .div_level_q  (div_level),
        .period_q     (period),
        .period_chg_q (period_chg)
    );

    // power mode decode
    acpm_pkg::acpm_pwr_t pwr_d;
    always_comb begin
        unique case (pm_q)
            acpm_pkg::PM_DOWN: pwr_d = '0;
            acpm_pkg::PM_STBY: pwr_d = '{ref_en: 1'b1, default: 1'b0};
            default:           pwr_d = '1;
        endcase
    end

    // stabilizer lock loop
    logic                          loop_ok;
    logic [acpm_pkg::RELOCK_W-1:0] relock_q, relock_d;
    assign loop_ok = dcs_en_q & pwr_q.clk_en & (period != '0) &
                     (period <= acpm_pkg::PER_W'(acpm_pkg::DCS_MAX_PER_CYC));

    always_comb begin
        st_d     = st_q;
        relock_d = relock_q;
        unique case (st_q)
            acpm_pkg::LS_OFF: begin
                relock_d = '0;
                if (loop_ok) st_d = acpm_pkg::LS_WAIT;
            end
            acpm_pkg::LS_WAIT: begin
                relock_d = relock_q + 1'b1;
                // settle for the relock time
                if (!loop_ok) begin
                    st_d = acpm_pkg::LS_OFF;
                end else if (period_chg) begin
                    relock_d = '0;
                end else if (relock_q ==
                             acpm_pkg::RELOCK_W'(acpm_pkg::RELOCK_MIN_CYC - 1)) begin
                    st_d = acpm_pkg::LS_LOCK;
                end
            end
            acpm_pkg::LS_LOCK: begin
                relock_d = '0;
                if (!loop_ok) st_d = acpm_pkg::LS_OFF;
                else if (period_chg) st_d = acpm_pkg::LS_WAIT;
            end
            default: begin
                st_d     = acpm_pkg::LS_OFF;
                relock_d = '0;
            end
        endcase
    end

    // internal clock generation
    logic [acpm_pkg::PER_W-1:0] ph_q, ph_d;
    logic                       iclk_d, strobe_d;
    always_comb begin
        ph_d = div_rise ? acpm_pkg::PER_W'(1) : (&ph_q ? ph_q : ph_q + 1'b1);
        if (!pwr_q.clk_en) begin
            iclk_d = 1'b0;
        end else if (st_q == acpm_pkg::LS_LOCK) begin
            iclk_d = div_rise | (iclk_q & (ph_q < (period >> 1)));
        end else begin
            iclk_d = div_level;
        end
        strobe_d = iclk_d & ~iclk_q;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q            <= acpm_pkg::LS_OFF;
            relock_q        <= '0;
            ph_q            <= '0;
            iclk_q          <= 1'b0;
            sample_strobe_q <= 1'b0;
            pwr_q           <= '1;
            dcs_locked_q    <= 1'b0;
            span_q          <= acpm_pkg::SPAN_BASE;
            data_out_q      <= '0;
            data_oe_q       <= 1'b0;
        end else begin
            st_q            <= st_d;
            relock_q        <= relock_d;
            ph_q            <= ph_d;
            iclk_q          <= iclk_d;
            sample_strobe_q <= strobe_d;
            pwr_q           <= pwr_d;
            dcs_locked_q    <= (st_d == acpm_pkg::LS_LOCK);
            span_q          <= acpm_pkg::SPAN_BASE +
                               8'(vref_q) * acpm_pkg::SPAN_STEP;
            data_out_q      <= pwr_q.out_en ? conv_data : '0;
            data_oe_q       <= pwr_q.out_en;
        end
    end

    // checks
    property p_pd_write;
        @(posedge ref_clk) disable iff (reset)
        (reg_wr && reg_addr == acpm_pkg::ADDR_PWR && reg_wdata[1:0] == acpm_pkg::PM_DOWN)
            |-> ##3 !data_oe_q && !pwr_q.clk_en;
    endproperty
    a_pd_write: assert property (p_pd_write) else $error("power-down write not honoured");

    property p_hiz;
        @(posedge ref_clk) disable iff (reset)
        !pwr_q.out_en |=> !data_oe_q;
    endproperty
    a_hiz: assert property (p_hiz) else $error("data drivers on while down");

    property p_down_off;
        @(posedge ref_clk) disable iff (reset)
        (pm_q == acpm_pkg::PM_DOWN) [*2] |-> pwr_q == '0 ##1 !iclk_q;
    endproperty
    a_down_off: assert property (p_down_off) else $error("power-down left a block on");

    property p_stby;
        @(posedge ref_clk) disable iff (reset)
        pm_q == acpm_pkg::PM_STBY |=> pwr_q.ref_en && !pwr_q.clk_en && !pwr_q.bias_en;
    endproperty
    a_stby: assert property (p_stby) else $error("standby enables wrong");

    property p_norm;
        @(posedge ref_clk) disable iff (reset)
        pm_q == acpm_pkg::PM_NORM |=> pwr_q == '1;
    endproperty
    a_norm: assert property (p_norm) else $error("normal mode not fully on");

    property p_relock;
        @(posedge ref_clk) disable iff (reset)
        $rose(st_q == acpm_pkg::LS_LOCK) |->
            $past(relock_q) == acpm_pkg::RELOCK_W'(acpm_pkg::RELOCK_MIN_CYC - 1);
    endproperty
    a_relock: assert property (p_relock) else $error("locked before relock time");

    property p_slow;
        @(posedge ref_clk) disable iff (reset)
        period > acpm_pkg::PER_W'(acpm_pkg::DCS_MAX_PER_CYC) |=> st_q != acpm_pkg::LS_LOCK;
    endproperty
    a_slow: assert property (p_slow) else $error("loop locked on slow clock");

    property p_bypass;
        @(posedge ref_clk) disable iff (reset)
        (st_q != acpm_pkg::LS_LOCK && pwr_q.clk_en) |=> iclk_q == $past(div_level);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not following input");

    property p_half;
        @(posedge ref_clk) disable iff (reset)
        (st_q == acpm_pkg::LS_LOCK && pwr_q.clk_en && div_rise) |=> iclk_q;
    endproperty
    a_half: assert property (p_half) else $error("stabilized clock missed edge");

    property p_strobe;
        @(posedge ref_clk) disable iff (reset)
        sample_strobe_q |-> iclk_q && !$past(iclk_q);
    endproperty
    a_strobe: assert property (p_strobe) else $error("sample strobe off rising edge");

    property p_rst_dcs;
        @(posedge ref_clk) disable iff (reset)
        $fell(reset) |-> dcs_en_q == (DIV_RST != acpm_pkg::DIV_FIELD_ONE);
    endproperty
    a_rst_dcs: assert property (p_rst_dcs) else $error("stabilizer reset default wrong");

    property p_span;
        @(posedge ref_clk) disable iff (reset)
        (reg_wr && reg_addr == acpm_pkg::ADDR_VREF) |-> ##2
            span_q == acpm_pkg::SPAN_BASE + 8'($past(reg_wdata[acpm_pkg::VREF_W-1:0], 2))
                      * acpm_pkg::SPAN_STEP;
    endproperty
    a_span: assert property (p_span) else $error("span not tracking reference");

    property p_div;
        @(posedge ref_clk) disable iff (reset)
        div_rise |=> !div_rise;
    endproperty
    a_div: assert property (p_div) else $error("divider output too fast");
endmodule
`default_nettype wire

// [testbench/acpm_tb.sv]
// testbench: self-checking bench for acpm_top clock divider, stabilizer, power modes, span
// assumes the register port is driven directly, with no serial decoder in front
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                 ref_clk;
    logic                 reset;
    logic                 sample_clk_pin = 1'b0;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [7:0]           reg_addr;
    logic [7:0]           reg_wdata;
    logic [7:0]           reg_rdata_q;
    logic [11:0]          conv_data;
    logic [11:0]          data_out_q;
    logic                 data_oe_q;
    logic                 iclk_q;
    logic                 sample_strobe_q;
    acpm_pkg::acpm_pwr_t  pwr_q;
    logic [7:0]           span_q;
    logic                 dcs_locked_q;
    int                   err_total = 0;
    int                   samples_checked = 0;
    int                   half = 0;
    int                   pin_cnt = 0;
    int                   strobes = 0;

    acpm_top #(.DATA_W(12), .DIV_RST(3'h2)) u_dut (
        .ref_clk(ref_clk), .reset(reset), .sample_clk_pin(sample_clk_pin),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .conv_data(conv_data), .data_out_q(data_out_q),
        .data_oe_q(data_oe_q), .iclk_q(iclk_q), .sample_strobe_q(sample_strobe_q),
        .pwr_q(pwr_q), .span_q(span_q), .dcs_locked_q(dcs_locked_q)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // raw sample clock, toggles every half ref cycles, idle low when stopped
    always @(negedge ref_clk) begin
        if (half != 0) begin
            pin_cnt++;
            if (pin_cnt >= half) begin
                sample_clk_pin = ~sample_clk_pin;
                pin_cnt = 0;
            end
        end else begin
            sample_clk_pin = 1'b0;
        end
        if (sample_strobe_q === 1'b1) begin
            strobes++;
            chk("iclk_at_strobe", 16'h1, {15'h0, iclk_q});
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        chk("read", {8'h0, exp}, {8'h0, reg_rdata_q});
    endtask

    task automatic t_reset();
        chk("pwr_rst", 16'h1f, {11'h0, pwr_q});
        chk("span_rst", 16'h8c, {8'h0, span_q});
        chk("lock_rst", 16'h0, {15'h0, dcs_locked_q});
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h09, 8'h01);
        rd_chk(8'h0b, 8'h02);
        chk("oe_rst", 16'h1, {15'h0, data_oe_q});
        $display("test reset done");
    endtask

    task automatic t_power();
        logic [1:0] md [4];
        logic [4:0] ep [4];
        logic       hi;
        md = '{2'h1, 2'h2, 2'h0, 2'h3};
        ep = '{5'h00, 5'h10, 5'h1f, 5'h1f};
        half = 2;
        for (int i = 0; i < 4; i++) begin
            conv_data = {8'h5a, 2'h0, md[i]};
            wr(8'h08, {6'h3f, md[i]});
            cyc(6);
            hi = 1'b0;
            repeat (20) begin
                @(negedge ref_clk);
                hi = hi | iclk_q;
            end
            chk("pwr", {11'h0, ep[i]}, {11'h0, pwr_q});
            chk("oe", {15'h0, ep[i][0]}, {15'h0, data_oe_q});
            chk("dout", ep[i][0] ? {4'h0, conv_data} : 16'h0, {4'h0, data_out_q});
            chk("iclk_run", {15'h0, ep[i][1]}, {15'h0, hi});
            rd_chk(8'h08, {6'h0, md[i]});
        end
        $display("test power done");
    endtask

    task automatic t_div();
        int n;
        int n0;
        half = 4;
        wr(8'h09, 8'h00);
        for (int r = 0; r < 8; r++) begin
            wr(8'h0b, r[7:0]);
            cyc(40);
            n0 = strobes;
            cyc(128 * (r + 1));
            n = strobes - n0;
            chk("div_strobes", 16'h1, {15'h0, (n >= 15 && n <= 17)});
        end
        $display("test divider done");
    endtask

    task automatic t_lock();
        int k;
        int h;
        wr(8'h0b, 8'h00);
        half = 1;
        wr(8'h09, 8'h01);
        cyc(145);
        chk("early_lock", 16'h0, {15'h0, dcs_locked_q});
        k = 0;
        while (dcs_locked_q !== 1'b1 && k < 370) begin
            cyc(1);
            k++;
        end
        chk("locked", 16'h1, {15'h0, dcs_locked_q});
        h = 0;
        repeat (40) begin
            @(negedge ref_clk);
            h += (iclk_q === 1'b1) ? 1 : 0;
        end
        chk("lock_duty", 16'h14, 16'(h));
        rd_chk(8'h0a, 8'h04);
        half = 4;
        cyc(60);
        chk("slow_unlock", 16'h0, {15'h0, dcs_locked_q});
        rd_chk(8'h0a, 8'h01);
        $display("test lock done");
    endtask

    task automatic t_span();
        for (int v = 0; v < 32; v++) begin
            wr(8'h18, v[7:0]);
            cyc(3);
            chk("span", 16'h8c + 16'(v * 2), {8'h0, span_q});
        end
        rd_chk(8'h18, 8'h1f);
        wr(8'h3f, 8'h55);
        rd_chk(8'h3f, 8'h00);
        rd_chk(8'h18, 8'h1f);
        $display("test span done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #500us;
        err_total++;
        results();
    end

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        conv_data = 12'h5a3;
        cyc(2);
        reset = 1'b0;
        cyc(1);
        t_reset();
        t_power();
        t_div();
        t_lock();
        t_span();
        results();
    end
endmodule
`default_nettype wire
